// ### common/handoff_cfg_pkg.sv
/*
 * Shared constants, field layouts, types and decode functions for the
 * startup handoff configuration bank and its duty floor stage.
 * Assumes a single 200 MHz APB clock domain and 32-bit APB data.
 */
package handoff_cfg_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0]  IDX_STARTUP2   = 8'h85;
    localparam logic [7:0]  IDX_CLOSED1    = 8'h86;
    localparam logic [7:0]  IDX_STATUS     = 8'h87;
    localparam logic [11:0] ADDR_STARTUP2  = {2'h0, IDX_STARTUP2, 2'h0};
    localparam logic [11:0] ADDR_CLOSED1   = {2'h0, IDX_CLOSED1, 2'h0};
    localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};

    // Field positions inside the second startup register.
    localparam int THR_LSB    = 8;
    localparam int AUTO_BIT   = 7;
    localparam int FIRST_BIT  = 6;
    localparam int MINDUTY_LSB = 2;

    // Reset values and writable masks; reserved bits read as zero.
    localparam logic [31:0] STARTUP2_RST  = 32'h0000_0000;
    localparam logic [31:0] CLOSED1_RST   = 32'h0000_0000;
    localparam logic [31:0] STARTUP2_MASK = 32'hFFFF_FFFC;
    localparam logic [31:0] CLOSED1_MASK  = 32'hFFFF_FFFE;

    // Duty values are in tenths of a percent; 1000 is full duty.
    localparam int DUTY_W = 10;
    localparam int HZ_W   = 16;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h000;
    localparam logic [HZ_W-1:0]   HZ_ZERO   = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSED} loop_state_t;

    // Decoded startup fields as the motor control logic consumes them.
    typedef struct packed {
        logic [4:0] loop_switch_speed_threshold;
        logic       auto_handoff;
        logic       initial_cycle_rate_choice;
        logic [3:0] min_duty_code;
    } startup_cfg_t;

    // Handoff speed code to electrical frequency in hertz.
    function automatic logic [HZ_W-1:0] thr_hz(input logic [4:0] code);
        logic [HZ_W-1:0] hz;
        hz = 16'h0001;
        case (code)
            5'h00: hz = 16'd1;    5'h01: hz = 16'd4;    5'h02: hz = 16'd8;
            5'h03: hz = 16'd12;   5'h04: hz = 16'd16;   5'h05: hz = 16'd20;
            5'h06: hz = 16'd24;   5'h07: hz = 16'd28;   5'h08: hz = 16'd32;
            5'h09: hz = 16'd36;   5'h0A: hz = 16'd40;   5'h0B: hz = 16'd45;
            5'h0C: hz = 16'd50;   5'h0D: hz = 16'd55;   5'h0E: hz = 16'd60;
            5'h0F: hz = 16'd65;   5'h10: hz = 16'd70;   5'h11: hz = 16'd75;
            5'h12: hz = 16'd80;   5'h13: hz = 16'd85;   5'h14: hz = 16'd90;
            5'h15: hz = 16'd100;  5'h16: hz = 16'd150;  5'h17: hz = 16'd200;
            5'h18: hz = 16'd250;  5'h19: hz = 16'd300;  5'h1A: hz = 16'd350;
            5'h1B: hz = 16'd400;  5'h1C: hz = 16'd450;  5'h1D: hz = 16'd500;
            5'h1E: hz = 16'd550;  default: hz = 16'd600;
        endcase
        return hz;
    endfunction

    // Minimum duty code to tenths of a percent.
    function automatic logic [DUTY_W-1:0] min_duty(input logic [3:0] code);
        logic [DUTY_W-1:0] d;
        d = 10'd15;
        case (code)
            4'h0: d = 10'd15;  4'h1: d = 10'd20;  4'h2: d = 10'd30;
            4'h3: d = 10'd40;  4'h4: d = 10'd50;  4'h5: d = 10'd60;
            4'h6: d = 10'd70;  4'h7: d = 10'd80;  4'h8: d = 10'd90;
            4'h9: d = 10'd100; 4'hA: d = 10'd120; 4'hB: d = 10'd150;
            4'hC: d = 10'd175; 4'hD: d = 10'd200; 4'hE: d = 10'd250;
            default: d = 10'd300;
        endcase
        return d;
    endfunction

endpackage

// ### src/duty_floor.sv
/*
 * Output duty stage: raises the commanded duty to the programmed floor
 * while the motor runs and forces zero on a deliberate stop.
 * Assumes the command and floor code are synchronous to pclk.
 */
`timescale 1ns/1ps
module duty_floor
    import handoff_cfg_pkg::*;
(
    input  wire logic              pclk,        // Bus and logic clock.
    input  wire logic              presetn,     // Asynchronous reset, active low.
    input  wire logic              running,     // Motor is being driven.
    input  wire logic [DUTY_W-1:0] duty_cmd,    // Requested duty, 0.1 % units.
    input  wire logic [3:0]        floor_code,  // Minimum duty code.
    output logic      [DUTY_W-1:0] duty_out_q   // Applied duty, 0.1 % units.
);

    logic [DUTY_W-1:0] floor_val;
    logic [DUTY_W-1:0] duty_out_d;

    // A stop is the only way below the floor, so zero wins over the clamp.
    always_comb
    begin
        floor_val  = min_duty(floor_code);
        duty_out_d = DUTY_ZERO;
        if (running)
        begin
            duty_out_d = (duty_cmd < floor_val) ? floor_val : duty_cmd;
        end
    end

    // Registered so the driver sees a glitch-free duty word.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            duty_out_q <= DUTY_ZERO;
        else
            duty_out_q <= duty_out_d;
    end

endmodule

// ### src/handoff_cfg.sv
/*
 * Startup handoff configuration bank with its APB slave, the open to
 * closed loop handoff sequencer and the first cycle rate selection.
 * Assumes one 200 MHz clock, synchronous inputs, and an APB master that
 * holds each request until pready is seen high.
 */
//
// Contract
// - Five-bit handoff code decodes to a frequency threshold; switch at it.
// - Auto handoff clear uses threshold; set lets automatic logic pick.
// - Initial cycle choice: zero uses slow initial rate, one starts at 0 Hz.
// - Four-bit minimum duty code decodes 1.5 % up to 30 %.
// - Closed loop configuration word at index 86h, zero after reset.
`timescale 1ns/1ps
module handoff_cfg
    import handoff_cfg_pkg::*;
(
    input  wire logic              pclk,              // 200 MHz clock.
    input  wire logic              presetn,           // Asynchronous reset, active low.
    input  wire logic              psel,              // APB select.
    input  wire logic              penable,           // APB access phase.
    input  wire logic              pwrite,            // APB write when high.
    input  wire logic [11:0]       paddr,             // APB byte address.
    input  wire logic [31:0]       pwdata,            // APB write data.
    input  wire logic [3:0]        pstrb,             // APB byte strobes.
    output logic      [31:0]       prdata,            // APB read data.
    output logic                   pready,            // APB ready.
    output logic                   pslverr,           // APB error, unmapped address.
    input  wire logic              motor_run,         // Motor run request.
    input  wire logic [HZ_W-1:0]   elec_hz,           // Estimated electrical speed.
    input  wire logic              auto_handoff_ok,   // Automatic handoff point reached.
    input  wire logic [HZ_W-1:0]   slow_initial_rate, // Slow first cycle rate.
    input  wire logic [DUTY_W-1:0] duty_cmd,          // Requested duty.
    output logic                   closed_loop,       // Closed loop active.
    output logic [HZ_W-1:0]        initial_rate_hz,   // First cycle rate.
    output logic [DUTY_W-1:0]      duty_out,          // Applied duty.
    output logic [31:0]            closed_loop_cfg,   // Closed loop word.
    output startup_cfg_t           startup_cfg        // Decoded startup fields.
);

    logic [31:0]  startup_settings_second_q;
    logic [31:0]  closed_loop_config_one_q;
    logic [31:0]  prdata_q;
    logic [HZ_W-1:0] initial_rate_q;
    logic [HZ_W-1:0] thr_val;
    loop_state_t  state_q;
    loop_state_t  state_d;
    logic         hit_startup;
    logic         hit_closed;
    logic         hit_status;
    logic         wr_en;
    logic [31:0]  strobe_mask;
    logic [31:0]  status_word;

    // Address decode; anything else answers with an error.
    assign hit_startup = (paddr == ADDR_STARTUP2);
    assign hit_closed  = (paddr == ADDR_CLOSED1);
    assign hit_status  = (paddr == ADDR_STATUS);
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~(hit_startup | hit_closed | hit_status);
    assign wr_en       = psel & penable & pwrite;
    assign strobe_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign prdata      = prdata_q;

    // Decoded field view of the startup register.
    assign startup_cfg.loop_switch_speed_threshold =
        startup_settings_second_q[THR_LSB+4:THR_LSB];
    assign startup_cfg.auto_handoff              = startup_settings_second_q[AUTO_BIT];
    assign startup_cfg.initial_cycle_rate_choice = startup_settings_second_q[FIRST_BIT];
    assign startup_cfg.min_duty_code = startup_settings_second_q[MINDUTY_LSB+3:MINDUTY_LSB];
    assign thr_val         = thr_hz(startup_cfg.loop_switch_speed_threshold);
    assign closed_loop_cfg = closed_loop_config_one_q;
    assign closed_loop     = (state_q == ST_CLOSED);
    assign initial_rate_hz = initial_rate_q;
    assign status_word     = {4'h0, thr_val, duty_out, closed_loop, state_q == ST_OPEN};

    // Startup settings; reserved low bits never store anything.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            startup_settings_second_q <= STARTUP2_RST;
        else if (wr_en && hit_startup)
            startup_settings_second_q <= ((pwdata & strobe_mask)
                | (startup_settings_second_q & ~strobe_mask)) & STARTUP2_MASK;
    end

    // Closed loop word clears fully at reset; bit 0 is reserved.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            closed_loop_config_one_q <= CLOSED1_RST;
        else if (wr_en && hit_closed)
            closed_loop_config_one_q <= ((pwdata & strobe_mask)
                | (closed_loop_config_one_q & ~strobe_mask)) & CLOSED1_MASK;
    end

    // Read data is captured in the setup cycle so the access phase needs no wait.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (hit_startup)
                prdata_q <= startup_settings_second_q;
            else if (hit_closed)
                prdata_q <= closed_loop_config_one_q;
            else if (hit_status)
                prdata_q <= status_word;
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // Handoff sequencer: open loop until the chosen switch point, then closed loop.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (motor_run)
                    state_d = ST_OPEN;
            ST_OPEN:
                if (!motor_run)
                    state_d = ST_IDLE;
                else if (startup_cfg.auto_handoff ? auto_handoff_ok
                                                  : (elec_hz >= thr_val))
                    state_d = ST_CLOSED;
            ST_CLOSED:
                if (!motor_run)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // First cycle rate follows the selection; zero hertz lets the rotor align first.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            initial_rate_q <= HZ_ZERO;
        else if (startup_cfg.initial_cycle_rate_choice)
            initial_rate_q <= HZ_ZERO;
        else
            initial_rate_q <= slow_initial_rate;
    end

    // Duty floor stage; a stopped sequencer counts as a deliberate stop.
    duty_floor u_floor
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .running    (state_q != ST_IDLE),
        .duty_cmd   (duty_cmd),
        .floor_code (startup_cfg.min_duty_code),
        .duty_out_q (duty_out)
    );

    // Checks on the handoff and duty behaviour.
    sequence s_open_ready_fixed;
        state_q == ST_OPEN && motor_run && !startup_cfg.auto_handoff && elec_hz >= thr_val;
    endsequence

    sequence s_open_ready_auto;
        state_q == ST_OPEN && motor_run && startup_cfg.auto_handoff && auto_handoff_ok;
    endsequence

    property p_fixed_handoff;
        @(posedge pclk) disable iff (!presetn)
        s_open_ready_fixed |=> closed_loop;
    endproperty
    a_fixed_handoff: assert property (p_fixed_handoff)
        else $error("Handoff missed at the programmed threshold.");

    property p_no_early_handoff;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_OPEN && !startup_cfg.auto_handoff && elec_hz < thr_val)
            |=> !closed_loop;
    endproperty
    a_no_early_handoff: assert property (p_no_early_handoff)
        else $error("Handoff below the programmed threshold.");

    property p_auto_handoff;
        @(posedge pclk) disable iff (!presetn)
        s_open_ready_auto |=> closed_loop;
    endproperty
    a_auto_handoff: assert property (p_auto_handoff)
        else $error("Automatic handoff not taken.");

    property p_auto_waits;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_OPEN && startup_cfg.auto_handoff && !auto_handoff_ok)
            |=> !closed_loop;
    endproperty
    a_auto_waits: assert property (p_auto_waits)
        else $error("Automatic mode switched without its signal.");

    property p_first_rate;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> initial_rate_hz == ($past(startup_cfg.initial_cycle_rate_choice)
                                     ? HZ_ZERO : $past(slow_initial_rate));
    endproperty
    a_first_rate: assert property (p_first_rate)
        else $error("First cycle rate does not follow its selection.");

    property p_duty_floor;
        @(posedge pclk) disable iff (!presetn)
        (state_q != ST_IDLE) |=> duty_out >= min_duty($past(startup_cfg.min_duty_code));
    endproperty
    a_duty_floor: assert property (p_duty_floor)
        else $error("Applied duty below the minimum floor.");

    property p_floor_top;
        @(posedge pclk) disable iff (!presetn)
        (state_q != ST_IDLE && startup_cfg.min_duty_code == 4'hF && duty_cmd == DUTY_ZERO)
            |=> duty_out == 10'd300;
    endproperty
    a_floor_top: assert property (p_floor_top)
        else $error("Top floor code does not give 30 percent.");

    property p_stop_zero;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE) |=> duty_out == DUTY_ZERO;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("Duty not zero after a stop.");

    property p_closed_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> closed_loop_config_one_q == CLOSED1_RST;
    endproperty
    a_closed_reset: assert property (p_closed_reset)
        else $error("Closed loop word not zero after reset.");

    property p_closed_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_closed && pstrb == 4'hF)
            |=> closed_loop_config_one_q == ($past(pwdata) & CLOSED1_MASK);
    endproperty
    a_closed_write: assert property (p_closed_write)
        else $error("Closed loop word write lost.");

endmodule

// ### bench/motor_startup_handoff_config_tb_top.sv
/*
 * Self-checking bench for the startup handoff configuration bank: APB
 * register access, handoff decision, first cycle rate and duty floor.
 * Assumes the APB slave answers in its own time and the state lags stated
 * for the block.
 */
`timescale 1ns/1ps
module motor_startup_handoff_config_tb_top;
    import handoff_cfg_pkg::*;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              motor_run = 1'b0;
    logic [HZ_W-1:0]   elec_hz = 16'h0000;
    logic              auto_handoff_ok = 1'b0;
    logic [HZ_W-1:0]   slow_initial_rate = 16'h0000;
    logic [DUTY_W-1:0] duty_cmd = 10'h000;
    logic              closed_loop;
    logic [HZ_W-1:0]   initial_rate_hz;
    logic [DUTY_W-1:0] duty_out;
    logic [31:0]       closed_loop_cfg;
    startup_cfg_t      startup_cfg;
    logic [31:0]       rd;
    logic              er;
    logic [31:0]       wd;
    int                n_errors = 0;
    int                n_compared = 0;
    int                cycles = 0;
    int                seed = 52618;
    int                want;
    // Duty floor per code in tenths of a percent; threshold codes and hertz.
    int floor_tab [16] = '{15, 20, 30, 40, 50, 60, 70, 80,
                           90, 100, 120, 150, 175, 200, 250, 300};
    int thr_code [3] = '{0, 23, 11};
    int thr_freq [3] = '{1, 200, 45};

    // The clock toggles every half period of 2.5 ns.
    always #2.5 pclk = ~pclk;

    handoff_cfg uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .motor_run(motor_run), .elec_hz(elec_hz), .auto_handoff_ok(auto_handoff_ok),
        .slow_initial_rate(slow_initial_rate), .duty_cmd(duty_cmd),
        .closed_loop(closed_loop), .initial_rate_hz(initial_rate_hz),
        .duty_out(duty_out), .closed_loop_cfg(closed_loop_cfg), .startup_cfg(startup_cfg)
    );

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d.", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Program the second startup register, random upper bits, and read it back.
    task automatic cfg(input logic [4:0] t, input logic a, input logic f, input logic [3:0] m);
        logic [31:0] v;
        v = $random(seed);
        v[12:0] = {t, a, f, m, 2'b00};
        apb(1'b1, ADDR_STARTUP2, v, rd, er);
        apb(1'b0, ADDR_STARTUP2, 32'h0000_0000, rd, er);
        chk("startup_rd", rd, v & STARTUP2_MASK);
        chk("min_code", {28'h0, startup_cfg.min_duty_code}, {28'h0, m});
        chk("cfg_fields", {21'h0, startup_cfg}, {21'h0, t, a, f, m});
    endtask

    // The whole run should need well under this many cycles.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, unmapped refusal and a masked read back.
        apb(1'b0, ADDR_CLOSED1, 32'h0, rd, er);
        chk("closed_rst", rd, 32'h0000_0000);
        chk("cfg_port", closed_loop_cfg, 32'h0000_0000);
        apb(1'b0, ADDR_STARTUP2, 32'h0, rd, er);
        chk("startup_rst", rd, 32'h0000_0000);
        apb(1'b0, 12'h3F0, 32'h0, rd, er);
        chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
        chk("unmapped_rd", rd, 32'h0000_0000);
        wd = $random(seed);
        apb(1'b1, ADDR_CLOSED1, wd, rd, er);
        apb(1'b0, ADDR_CLOSED1, 32'h0, rd, er);
        chk("closed_rd", rd, wd & CLOSED1_MASK);
        chk("cfg_port_wr", closed_loop_cfg, wd & CLOSED1_MASK);
        // A reset in mid-run must clear the word that was just written.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CLOSED1, 32'h0, rd, er);
        chk("closed_rst2", rd, 32'h0000_0000);
        chk("cfg_port_rst2", closed_loop_cfg, 32'h0000_0000);
        // Every floor code with a random command; the floor wins when larger.
        motor_run <= 1'b1;
        for (int c = 0; c < 16; c++)
        begin
            cfg(5'h1F, 1'b0, 1'b0, 4'(c));
            duty_cmd <= 10'({$random(seed)} % 401);
            repeat (4) @(posedge pclk);
            want = (int'(duty_cmd) > floor_tab[c]) ? int'(duty_cmd) : floor_tab[c];
            chk("duty_floor", {22'h0, duty_out}, want);
        end
        // A zero command under the top code must still give the top floor.
        duty_cmd <= DUTY_ZERO;
        repeat (3) @(posedge pclk);
        chk("duty_top", {22'h0, duty_out}, floor_tab[15]);
        // A deliberate stop forces zero duty.
        motor_run <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("duty_stop", {22'h0, duty_out}, 32'h0000_0000);
        // Handoff just below and at the programmed threshold.
        for (int i = 0; i < 3; i++)
        begin
            cfg(5'(thr_code[i]), 1'b0, 1'b0, 4'h0);
            elec_hz <= 16'(thr_freq[i] - 1);
            motor_run <= 1'b1;
            repeat (4) @(posedge pclk);
            chk("below_thr", {31'h0, closed_loop}, 32'h0000_0000);
            elec_hz <= 16'(thr_freq[i]);
            repeat (3) @(posedge pclk);
            chk("at_thr", {31'h0, closed_loop}, 32'h0000_0001);
            motor_run <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        // Automatic handoff ignores speed and waits for its own point.
        cfg(5'h00, 1'b1, 1'b0, 4'h0);
        elec_hz <= 16'hFFFF;
        motor_run <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("auto_wait", {31'h0, closed_loop}, 32'h0000_0000);
        auto_handoff_ok <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("auto_go", {31'h0, closed_loop}, 32'h0000_0001);
        // Status ignores writes and shows threshold, floored duty and loop state.
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, rd, er);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
        want = (thr_freq[0] << 12) | (floor_tab[0] << 2) | 2;
        chk("status_rd", rd, want);
        chk("mapped_err", {31'h0, er}, 32'h0000_0000);
        // First cycle rate from the slow rate, then from zero hertz.
        slow_initial_rate <= 16'($random(seed));
        cfg(5'h00, 1'b1, 1'b0, 4'h0);
        repeat (3) @(posedge pclk);
        chk("first_slow", {16'h0, initial_rate_hz}, {16'h0, slow_initial_rate});
        cfg(5'h00, 1'b1, 1'b1, 4'h0);
        repeat (3) @(posedge pclk);
        chk("first_zero", {16'h0, initial_rate_hz}, 32'h0000_0000);
        give_verdict();
    end
endmodule
